//--- rtl/capture_compare_timer.v
// Two-channel capture/compare timer with 16-bit up-counter and APB register access
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`include "timer_consts.vh"
module capture_compare_timer (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Timer pins
    input  wire        external_timer_clock_pin,
    input  wire        channel0_pin_in,
    output reg         channel0_pin_out,
    output reg         channel0_pin_oe,
    input  wire        channel1_pin_in,
    output reg         channel1_pin_out,
    output reg         channel1_pin_oe,
    // Interrupt requests
    output reg         irq_overflow,
    output reg         irq_channel0,
    output reg         irq_channel1
);
    // Counter and timer control state
    reg [`CNT_W-1:0] cnt_q;
    reg [`CNT_W-1:0] modulo_q;
    reg [`DIV_W-1:0] div_q;
    reg [2:0]        ps_q;
    reg              halt_q;
    reg              ovf_ie_q;
    reg              ovf_flag_q;
    reg              ovf_arm_q;
    reg              upd_q;
    reg              ovf_q;
    // Channel state
    reg [1:0]        flag_q;
    reg [1:0]        arm_q;
    reg [1:0]        ie_q;
    reg [1:0]        msa_q;
    reg [1:0]        elsb_q;
    reg [1:0]        elsa_q;
    reg [1:0]        tov_q;
    reg              link_q;
    reg              active_q;
    reg              last_wr_q;
    reg [`CNT_W-1:0] val0_q;
    reg [`CNT_W-1:0] val1_q;

    wire ext_rise;
    wire ch0_rise;
    wire ch0_fall;
    wire ch1_rise;
    wire ch1_fall;

    pin_sync_edge u_ext_sync (
        .clock (clock),
        .rstn  (rstn),
        .pin   (external_timer_clock_pin),
        .rise  (ext_rise),
        .fall  ()
    );
    pin_sync_edge u_ch0_sync (
        .clock (clock),
        .rstn  (rstn),
        .pin   (channel0_pin_in),
        .rise  (ch0_rise),
        .fall  (ch0_fall)
    );
    pin_sync_edge u_ch1_sync (
        .clock (clock),
        .rstn  (rstn),
        .pin   (channel1_pin_in),
        .rise  (ch1_rise),
        .fall  (ch1_fall)
    );

    // Low bits of the divider that must all be set for a tick at rate 2**ps
    function [`DIV_W-1:0] div_mask;
        input [2:0] ps;
        begin
            div_mask = (7'h01 << ps) - 7'h01;
        end
    endfunction

    // Capture trigger for one channel
    function edge_hit;
        input [1:0] els;
        input       rise;
        input       fall;
        begin
            edge_hit = (els[0] & rise) | (els[1] & fall);
        end
    endfunction

    // Pin level after a compare
    function oc_action;
        input [1:0] els;
        input       cur;
        begin
            case (els)
                `ELS_TOGGLE: oc_action = ~cur;
                `ELS_CLEAR:  oc_action = 1'b0;
                `ELS_SET:    oc_action = 1'b1;
                default:     oc_action = cur;
            endcase
        end
    endfunction

    // APB phases: zero wait states, answer registered in the setup cycle
    wire setup   = psel & ~penable;
    wire done    = psel & penable & pready;
    wire wr_done = done & pwrite & ~pslverr;
    wire rd_done = done & ~pwrite & ~pslverr;

    wire wr_tctl = wr_done & (paddr == `OFS_TIMER_CTL);
    wire wr_mod  = wr_done & (paddr == `OFS_MODULO);
    wire wr_c0   = wr_done & (paddr == `OFS_CH0_CTL);
    wire wr_v0   = wr_done & (paddr == `OFS_CH0_VALUE);
    wire wr_c1   = wr_done & (paddr == `OFS_CH1_CTL) & ~link_q;
    wire wr_v1   = wr_done & (paddr == `OFS_CH1_VALUE);
    wire rd_tctl = rd_done & (paddr == `OFS_TIMER_CTL);
    wire rd_c0   = rd_done & (paddr == `OFS_CH0_CTL);
    wire rd_c1   = rd_done & (paddr == `OFS_CH1_CTL);

    wire addr_ok = (paddr == `OFS_TIMER_CTL) | (paddr == `OFS_COUNTER) | (paddr == `OFS_MODULO) |
                   (paddr == `OFS_CH0_CTL) | (paddr == `OFS_CH0_VALUE) |
                   (paddr == `OFS_CH1_CTL) | (paddr == `OFS_CH1_VALUE);

    // Clock selection and counting
    wire cnt_clr = wr_tctl & pwdata[`BIT_CNT_RESET];
    wire [`DIV_W-1:0] mask = div_mask(ps_q);
    wire tick = (ps_q == `PS_EXT_CLOCK) ? ext_rise : ((div_q & mask) == mask);
    wire step = tick & ~halt_q & ~cnt_clr;
    wire wrap = (cnt_q == modulo_q);

    // Channel modes
    wire [1:0] els0 = {elsb_q[0], elsa_q[0]};
    wire [1:0] els1 = {elsb_q[1], elsa_q[1]};
    wire ic0 = ~link_q & ~msa_q[0] & (els0 != `ELS_OFF);
    wire oc0 = (link_q | msa_q[0]) & (els0 != `ELS_OFF);
    wire ic1 = ~link_q & ~msa_q[1] & (els1 != `ELS_OFF);
    wire oc1 = ~link_q & msa_q[1] & (els1 != `ELS_OFF);

    // Compare only on exact equality, right after each count update
    wire [`CNT_W-1:0] cmp0_val = (link_q & active_q) ? val1_q : val0_q;
    wire cmp0 = upd_q & oc0 & (cnt_q == cmp0_val);
    wire cmp1 = upd_q & oc1 & (cnt_q == val1_q);
    wire cap0 = ic0 & edge_hit(els0, ch0_rise, ch0_fall);
    wire cap1 = ic1 & edge_hit(els1, ch1_rise, ch1_fall);
    wire [1:0] ev = {cmp1 | cap1, cmp0 | cap0};

    // Flag clears need a read that saw the flag set, then a write of zero
    wire ovf_clr = wr_tctl & ~pwdata[`BIT_OVF_FLAG] & ovf_arm_q;
    wire [1:0] ch_clr = {wr_c1 & ~pwdata[`BIT_CH_FLAG] & arm_q[1],
                         wr_c0 & ~pwdata[`BIT_CH_FLAG] & arm_q[0]};
    wire [1:0] ch_rd = {rd_c1, rd_c0};

    // Counter, prescaler and timer control
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q      <= `RST_COUNTER;
            div_q      <= {`DIV_W{1'b0}};
            modulo_q   <= `RST_MODULO;
            ps_q       <= `RST_PS;
            halt_q     <= 1'b0;
            ovf_ie_q   <= 1'b0;
            ovf_flag_q <= 1'b0;
            ovf_arm_q  <= 1'b0;
            upd_q      <= 1'b0;
            ovf_q      <= 1'b0;
        end else begin
            if (cnt_clr) begin
                cnt_q <= `RST_COUNTER;
                div_q <= {`DIV_W{1'b0}};
            end else if (!halt_q) begin
                div_q <= div_q + 7'h01;
                if (tick) begin
                    cnt_q <= wrap ? `RST_COUNTER : cnt_q + 16'h0001;
                end
            end
            upd_q <= step;
            ovf_q <= step & wrap;
            if (wr_mod) begin
                modulo_q <= pwdata[`CNT_W-1:0];
            end
            if (wr_tctl) begin
                ps_q     <= pwdata[`PS_MSB:`PS_LSB];
                halt_q   <= pwdata[`BIT_HALT];
                ovf_ie_q <= pwdata[`BIT_OVF_IE];
            end
            // Set wins over clear, so a rollover during the clear is kept
            ovf_flag_q <= (step & wrap) | (ovf_flag_q & ~ovf_clr);
            if (step & wrap) begin
                ovf_arm_q <= 1'b0;
            end else if (rd_tctl & prdata[`BIT_OVF_FLAG]) begin
                ovf_arm_q <= 1'b1;
            end else if (ovf_clr) begin
                ovf_arm_q <= 1'b0;
            end
        end
    end

    // Channel control and value registers
    always @(posedge clock or negedge rstn) begin : chan
        integer i;
        if (!rstn) begin
            flag_q    <= 2'h0;
            arm_q     <= 2'h0;
            ie_q      <= 2'h0;
            msa_q     <= 2'h0;
            elsb_q    <= 2'h0;
            elsa_q    <= 2'h0;
            tov_q     <= 2'h0;
            link_q    <= 1'b0;
            active_q  <= 1'b0;
            last_wr_q <= 1'b0;
            val0_q    <= 16'h0000;
            val1_q    <= 16'h0000;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                flag_q[i] <= ev[i] | (flag_q[i] & ~ch_clr[i]);
                if (ev[i]) begin
                    arm_q[i] <= 1'b0;
                end else if (ch_rd[i] & prdata[`BIT_CH_FLAG]) begin
                    arm_q[i] <= 1'b1;
                end else if (ch_clr[i]) begin
                    arm_q[i] <= 1'b0;
                end
            end
            if (wr_c0) begin
                ie_q[0]   <= pwdata[`BIT_CH_IE];
                link_q    <= pwdata[`BIT_LINK];
                msa_q[0]  <= pwdata[`BIT_MS_LOW];
                elsb_q[0] <= pwdata[`BIT_ELS_HIGH];
                elsa_q[0] <= pwdata[`BIT_ELS_LOW];
                tov_q[0]  <= pwdata[`BIT_OVF_TOGGLE];
            end
            if (wr_c1) begin
                ie_q[1]   <= pwdata[`BIT_CH_IE];
                msa_q[1]  <= pwdata[`BIT_MS_LOW];
                elsb_q[1] <= pwdata[`BIT_ELS_HIGH];
                elsa_q[1] <= pwdata[`BIT_ELS_LOW];
                tov_q[1]  <= pwdata[`BIT_OVF_TOGGLE];
            end
            // Captures win over a software write in the same cycle
            if (cap0) begin
                val0_q <= cnt_q;
            end else if (wr_v0) begin
                val0_q <= pwdata[`CNT_W-1:0];
            end
            if (cap1) begin
                val1_q <= cnt_q;
            end else if (wr_v1) begin
                val1_q <= pwdata[`CNT_W-1:0];
            end
            // Buffered pair: channel 0 set starts in control
            if (!link_q) begin
                active_q  <= 1'b0;
                last_wr_q <= 1'b0;
            end else begin
                if (wr_v1) begin
                    last_wr_q <= 1'b1;
                end else if (wr_v0) begin
                    last_wr_q <= 1'b0;
                end
                if (ovf_q) begin
                    active_q <= last_wr_q;
                end
            end
        end
    end

    // Pins and interrupt requests
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            channel0_pin_out <= 1'b1;
            channel0_pin_oe  <= 1'b0;
            channel1_pin_out <= 1'b1;
            channel1_pin_oe  <= 1'b0;
            irq_overflow     <= 1'b0;
            irq_channel0     <= 1'b0;
            irq_channel1     <= 1'b0;
        end else begin
            // Preset level while the pin is under port control
            if (els0 == `ELS_OFF) begin
                channel0_pin_out <= ~msa_q[0];
            end else if (oc0 & ovf_q & tov_q[0]) begin
                channel0_pin_out <= ~channel0_pin_out;
            end else if (cmp0) begin
                channel0_pin_out <= oc_action(els0, channel0_pin_out);
            end
            if (els1 == `ELS_OFF) begin
                channel1_pin_out <= ~msa_q[1];
            end else if (oc1 & ovf_q & tov_q[1]) begin
                channel1_pin_out <= ~channel1_pin_out;
            end else if (cmp1) begin
                channel1_pin_out <= oc_action(els1, channel1_pin_out);
            end
            channel0_pin_oe <= oc0;
            channel1_pin_oe <= oc1;
            irq_overflow    <= ovf_flag_q & ovf_ie_q;
            irq_channel0    <= flag_q[0] & ie_q[0];
            irq_channel1    <= flag_q[1] & ie_q[1] & ~link_q;
        end
    end

    // APB slave
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= ~addr_ok;
                prdata  <= 32'h00000000;
                if (!pwrite) begin
                    case (paddr)
                        `OFS_TIMER_CTL: prdata <= {24'h000000, ovf_flag_q, ovf_ie_q, halt_q, 2'h0, ps_q};
                        `OFS_COUNTER:   prdata <= {16'h0000, cnt_q};
                        `OFS_MODULO:    prdata <= {16'h0000, modulo_q};
                        `OFS_CH0_CTL:   prdata <= {24'h000000, flag_q[0], ie_q[0], link_q, msa_q[0],
                                                   elsb_q[0], elsa_q[0], tov_q[0], 1'b0};
                        `OFS_CH0_VALUE: prdata <= {16'h0000, val0_q};
                        `OFS_CH1_CTL:   prdata <= {24'h000000, flag_q[1], ie_q[1], 1'b0, msa_q[1],
                                                   elsb_q[1], elsa_q[1], tov_q[1], 1'b0};
                        `OFS_CH1_VALUE: prdata <= {16'h0000, val1_q};
                        default:        prdata <= 32'h00000000;
                    endcase
                end
            end else if (done) begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule // capture_compare_timer

//--- rtl/timer_consts.vh
// Register offsets, field positions, reset values and widths of the capture/compare timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register byte offsets on the APB
`define OFS_TIMER_CTL   8'h00
`define OFS_COUNTER     8'h04
`define OFS_MODULO      8'h08
`define OFS_CH0_CTL     8'h0c
`define OFS_CH0_VALUE   8'h10
`define OFS_CH1_CTL     8'h14
`define OFS_CH1_VALUE   8'h18

// Timer control register fields
`define BIT_OVF_FLAG    7
`define BIT_OVF_IE      6
`define BIT_HALT        5
`define BIT_CNT_RESET   4
`define PS_MSB          2
`define PS_LSB          0
`define PS_EXT_CLOCK    3'h7

// Channel control register fields
`define BIT_CH_FLAG     7
`define BIT_CH_IE       6
`define BIT_LINK        5
`define BIT_MS_LOW      4
`define BIT_ELS_HIGH    3
`define BIT_ELS_LOW     2
`define BIT_OVF_TOGGLE  1

// Edge/level encodings
`define ELS_OFF         2'h0
`define ELS_TOGGLE      2'h1
`define ELS_CLEAR       2'h2
`define ELS_SET         2'h3

// Reset values
`define RST_MODULO      16'hffff
`define RST_COUNTER     16'h0000
`define RST_PS          3'h0

// Widths
`define CNT_W           16
`define DIV_W           7

`endif

//--- rtl/pin_sync_edge.v
// Two-stage synchroniser with edge detection for one timer pin
`timescale 1ns/1ns
module pin_sync_edge (
    // Clock and reset
    input  wire clock,
    input  wire rstn,
    // Pin and detected edges
    input  wire pin,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges only from the second stage on, so each edge is seen once
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule // pin_sync_edge

//--- dv/timer_pins_model.sv
// Far-side pin model: timer clock bursts and capture pin levels
`timescale 1ns/1ns
module timer_pins_model (
    // Pin drive from the timer
    input  logic ch0_oe,
    input  logic ch0_out,
    input  logic ch1_oe,
    input  logic ch1_out,
    // Pin levels seen by the timer
    output logic ext_clk,
    output logic ch0_level,
    output logic ch1_level
);
    logic drv0 = 1'b0;
    logic drv1 = 1'b0;
    initial ext_clk = 1'b0;
    // Stands still between bursts; phase unrelated to the bus clock
    task automatic burst(input int n);
        repeat (n) begin
            #17 ext_clk = 1'b1;
            #23 ext_clk = 1'b0;
        end
    endtask
    assign ch0_level = ch0_oe ? ch0_out : drv0;
    assign ch1_level = ch1_oe ? ch1_out : drv1;
endmodule // timer_pins_model

//--- dv/capture_compare_timer_checker.sv
// Bus protocol checker for the capture/compare timer ports
`timescale 1ns/1ns
module capture_compare_timer_checker (
    // Clock and reset
    input logic        clock,
    input logic        rstn,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Pins and requests
    input logic        external_timer_clock_pin,
    input logic        channel0_pin_in,
    input logic        channel0_pin_out,
    input logic        channel0_pin_oe,
    input logic        channel1_pin_in,
    input logic        channel1_pin_out,
    input logic        channel1_pin_oe,
    input logic        irq_overflow,
    input logic        irq_channel0,
    input logic        irq_channel1
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire bad_addr = paddr[1:0] != 2'h0 || paddr > 8'h18;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_next: assert property (s_setup |=> pready) else $error("pready late");
    a_ready_single: assert property (pready |=> !pready) else $error("pready held");
    a_ready_access: assert property (pready |-> s_access) else $error("pready outside access");
    a_error_unmapped: assert property (s_setup ##0 bad_addr |=> pslverr) else $error("no error");
    a_error_mapped: assert property (s_setup ##0 !bad_addr |=> !pslverr) else $error("false error");
    a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
    a_error_data: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
endmodule // capture_compare_timer_checker

bind capture_compare_timer capture_compare_timer_checker u_checker (.*);

//--- dv/capture_compare_timer_tb_top.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ns
module capture_compare_timer_tb_top;
    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
        logic        err;
    } note_t;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  cmp_mode [3] = '{8'h58, 8'h5c, 8'h54};
    wire  [31:0] prdata;
    wire         pready, pslverr, ext_clk, in0, in1, out0, oe0, out1, oe1;
    wire         irq_overflow, irq_channel0, irq_channel1;
    note_t       notes[$];
    note_t       n;
    int          mismatches = 0;
    int          checks = 0;
    int          i, k;

    always #5 clock = ~clock;

    capture_compare_timer u_dut (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_timer_clock_pin(ext_clk), .channel0_pin_in(in0), .channel0_pin_out(out0),
        .channel0_pin_oe(oe0), .channel1_pin_in(in1), .channel1_pin_out(out1),
        .channel1_pin_oe(oe1), .irq_overflow(irq_overflow), .irq_channel0(irq_channel0),
        .irq_channel1(irq_channel1)
    );
    timer_pins_model pins (
        .ch0_oe(oe0), .ch0_out(out0), .ch1_oe(oe1), .ch1_out(out1),
        .ext_clk(ext_clk), .ch0_level(in0), .ch1_level(in1)
    );

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, lo, hi);
        note_t e;
        e.lo = lo;
        e.hi = hi;
        e.err = a[1:0] != 2'h0 || a > 8'h18;
        notes.push_back(e);
        @(posedge clock);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] lo, hi);
        apb(1'b0, a, 32'h0, lo, hi);
    endtask
    task chk(input logic v, input logic e);
        checks++;
        if (v !== e) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, v, e);
        end
    endtask
    task run(input int c);
        pins.burst(c);
        repeat (4) @(posedge clock);
    endtask
    task cnt(input int c);
        wr(8'h00, 32'h17);
        run(c);
    endtask
    task results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Oldest note answers each completed transfer
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            n = notes.pop_front();
            checks++;
            if ((prdata >= n.lo) !== 1'b1 || (prdata <= n.hi) !== 1'b1 || pslverr !== n.err) begin
                mismatches++;
                $display("FAIL %0t got %h exp %h", $time, prdata, n.lo);
            end
        end
    end

    initial begin
        #400000;
        mismatches++;
        results();
    end

    initial begin
        void'($urandom(32'hbd0f));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(8'h08, 32'hffff, 32'hffff);
        rd(8'h0c, 32'h0, 32'h0);
        wr(8'h00, 32'h30);
        rd(8'h04, 32'h0, 32'h0);
        rd(8'h04, 32'h0, 32'h0);
        rd(8'h1c, 32'h0, 32'h0);
        rd(8'h02, 32'h0, 32'h0);
        $display("test reset_halt done");
        for (i = 0; i < 7; i++) begin
            wr(8'h00, 32'h10 | i);
            repeat (125) @(posedge clock);
            rd(8'h04, 120 >> i, (130 >> i) + 1);
        end
        $display("test prescaler done");
        wr(8'h08, 32'h5);
        wr(8'h00, 32'h50);
        repeat (20) @(posedge clock);
        chk(irq_overflow, 1'b1);
        wr(8'h00, 32'h60);
        rd(8'h04, 32'h0, 32'h5);
        rd(8'h00, 32'he0, 32'he0);
        wr(8'h00, 32'h60);
        rd(8'h00, 32'h60, 32'h60);
        chk(irq_overflow, 1'b0);
        $display("test overflow done");
        wr(8'h08, 32'hffff);
        for (i = 1; i < 4; i++) begin
            k = $urandom % 8 + 1;
            wr(8'h10, 32'h0);
            wr(8'h0c, 32'h40 | i << 2);
            cnt(k);
            pins.drv0 <= 1'b1;
            repeat (6) @(posedge clock);
            run(3);
            pins.drv0 <= 1'b0;
            repeat (6) @(posedge clock);
            rd(8'h10, i == 1 ? k : k + 3, i == 1 ? k : k + 3);
            chk(irq_channel0, 1'b1);
            rd(8'h0c, 32'hc0 | i << 2, 32'hc0 | i << 2);
            wr(8'h0c, 32'h0);
        end
        $display("test capture done");
        // Channel 1 as clear-on-compare alongside channel 0
        wr(8'h18, 32'h3);
        wr(8'h14, 32'h58);
        wr(8'h10, 32'h3);
        for (i = 0; i < 3; i++) begin
            wr(8'h0c, cmp_mode[i]);
            cnt(3);
            chk(oe0, 1'b1);
            chk(out0, i == 1);
        end
        chk(oe1, 1'b1);
        chk(out1, 1'b0);
        chk(irq_channel1, 1'b1);
        wr(8'h10, 32'h9);
        wr(8'h08, 32'h4);
        wr(8'h0c, 32'h5a);
        cnt(5);
        chk(out0, 1'b1);
        // Unbuffered value changes made at the safe moments
        wr(8'h0c, 32'h54);
        wr(8'h10, 32'h3);
        cnt(3);
        chk(out0, 1'b0);
        wr(8'h10, 32'h1);
        run(3);
        chk(out0, 1'b1);
        run(4);
        wr(8'h10, 32'h3);
        run(3);
        chk(out0, 1'b0);
        $display("test compare done");
        wr(8'h08, 32'h7);
        wr(8'h10, 32'h2);
        wr(8'h0c, 32'h64);
        cnt(2);
        chk(oe1, 1'b0);
        chk(out0, 1'b1);
        wr(8'h18, 32'h5);
        run(8);
        chk(out0, 1'b1);
        run(3);
        chk(out0, 1'b0);
        rd(8'h0c, 32'he4, 32'he4);
        chk(irq_channel1, 1'b0);
        $display("test linked done");
        results();
    end
endmodule // capture_compare_timer_tb_top
